// File: core/flash_guard_pkg.sv
// constants, types and register map of the self-programming flash guard
// assumes a word-addressed program flash and a 100 MHz system clock
package flash_guard_pkg;

  // flash geometry, in words
  localparam int AW     = 12;
  localparam int PAGE_W = 5;
  localparam int PG_W   = AW - PAGE_W;

  // fixed split between concurrent-read area and halting area
  localparam logic [AW-1:0] HALT_START = 12'hC00;

  // application/boot split, indexed by the boot-size fuses
  localparam logic [AW-1:0] BOOT_START_0 = 12'hC00;
  localparam logic [AW-1:0] BOOT_START_1 = 12'hE00;
  localparam logic [AW-1:0] BOOT_START_2 = 12'hF00;
  localparam logic [AW-1:0] BOOT_START_3 = 12'hF80;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAGE = 8'h04;
  localparam logic [7:0] OFS_LOCK  = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;

  // lock field positions, each bit low means programmed
  localparam int LK_APP_WR  = 0;
  localparam int LK_APP_RD  = 1;
  localparam int LK_BOOT_WR = 2;
  localparam int LK_BOOT_RD = 3;
  localparam logic [3:0] LOCK_UNPROG = 4'hF;

  // status field positions
  localparam int ST_AREA_BUSY = 0;
  localparam int ST_OP_BUSY   = 1;
  localparam int ST_STALL     = 2;
  localparam int ST_ARMED     = 3;
  localparam int ST_REFUSED   = 4;

  // timing
  localparam int CLK_MHZ      = 100;
  localparam int ARM_CYCLES   = 4;
  localparam int PROG_TIME_US = 4000;
  localparam int PROG_CYC_DEF = PROG_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_LOAD  = 3'b001,
    CMD_ERASE = 3'b010,
    CMD_WRITE = 3'b011,
    CMD_LOCK  = 3'b100,
    CMD_REEN  = 3'b101
  } cmd_t;

  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ARMED = 2'b01,
    S_PROG  = 2'b10
  } state_t;

  typedef struct packed {
    logic boot;
    logic halt;
  } area_t;

  typedef struct packed {
    logic          store;
    logic          lpm;
    logic [AW-1:0] pc;
    logic [AW-1:0] z;
  } cpu_req_t;

endpackage

// File: core/pin_sync3.sv
// three-stage synchroniser for a pin from outside the clock domain
// output changes only once stages two and three agree
`timescale 1ns/1ps
module pin_sync3
  import flash_guard_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // pin and clean level
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end

  assign level_o = lvl_ff;

endmodule // pin_sync3

// File: core/area_decode.sv
// classifies a flash word address into boot/application and halting areas
// assumes boot start already clamped into the halting area
`timescale 1ns/1ps
module area_decode
  import flash_guard_pkg::*;
(
  // address and boundary
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [AW-1:0] boot_start_i,
  // classification
  output area_t              area_o
);

  // concurrent-read/halting split ignores the fuses
  assign area_o.halt = (addr_i >= HALT_START);
  assign area_o.boot = (addr_i >= boot_start_i);

endmodule // area_decode

// File: core/flash_guard.sv
// self-programming access guard: AHB-Lite registers, store/load checks,
// cpu stall and concurrent-area busy; cpu and flash macro share CLK_I

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module flash_guard
  import flash_guard_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC_DEF
) (
  // clock and reset
  input  wire logic          CLK_I,
  input  wire logic          RESETN_I,
  // ahb-lite slave
  input  wire logic          HSEL_I,
  input  wire logic [31:0]   HADDR_I,
  input  wire logic [1:0]    HTRANS_I,
  input  wire logic          HWRITE_I,
  input  wire logic [2:0]    HSIZE_I,
  input  wire logic [31:0]   HWDATA_I,
  input  wire logic          HREADY_I,
  output logic      [31:0]   HRDATA_O,
  output logic               HREADYOUT_O,
  output logic               HRESP_O,
  // cpu side
  input  wire logic          STORE_I,
  input  wire logic          LPM_I,
  input  wire logic [AW-1:0] PC_I,
  input  wire logic [AW-1:0] Z_I,
  input  wire logic          VEC_IN_BOOT_I,
  output logic               STORE_REFUSED_O,
  output logic               LPM_ALLOW_O,
  output logic               CPU_STALL_O,
  output logic               AREA_READ_EN_O,
  output logic               IRQ_MASK_O,
  // fuses and programming pins
  input  wire logic [1:0]    BOOT_SIZE_FUSES_I,
  input  wire logic          CHIP_ERASE_I,
  // flash macro
  output logic               FL_ERASE_O,
  output logic               FL_WRITE_O,
  output logic               FL_LOAD_O,
  output logic [PG_W-1:0]    FL_PAGE_O
);

  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int AC = $clog2(ARM_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);
  localparam logic [AC-1:0] ARM_LAST  = AC'(ARM_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  cpu_req_t        req;
  area_t           pc_area;
  area_t           z_area;
  state_t          state_ff;
  state_t          nxt_state;
  cmd_t            cmd_ff;
  logic [3:0]      lock_ff;
  logic [3:0]      stage_ff;
  logic [1:0]      fuse_ff;
  logic            fuse_taken_ff;
  logic [AW-1:0]   boot_start;
  logic [AW-1:0]   fuse_start;
  logic            area_busy_ff;
  logic            stall_ff;
  logic            refused_ff;
  logic            refused_pls_ff;
  logic [CW-1:0]   prog_cnt_ff;
  logic [AC-1:0]   arm_cnt_ff;
  logic [PG_W-1:0] page_ff;
  logic            erase_pls_ff;
  logic            write_pls_ff;
  logic            load_pls_ff;
  logic            erase_lvl;
  logic            erase_old_ff;

  // bus signals
  logic            ap_valid;
  logic            wr_pend_ff;
  logic [7:0]      wr_ofs_ff;
  logic [31:0]     rd_mux;
  logic [31:0]     rdata_ff;
  logic            wr_ctrl;
  logic            wr_stage;
  logic [31:0]     status_word;

  // store decision
  logic            store_armed;
  logic            store_from_app;
  logic            tgt_wr_lock;
  logic            prog_cmd;
  logic            prog_ok;
  logic            prog_start;
  logic            load_go;
  logic            reen_go;
  logic            lock_go;
  logic            arm_expire;
  logic            prog_end;
  logic            busy_set;
  logic            busy_clr;
  logic            refuse_now;

  // load and interrupt decision
  logic            lpm_lock_blk;
  logic            lpm_busy_blk;
  logic            irq_app_mask;
  logic            irq_boot_mask;

  ////////////////////////////////////////////////////////////////////////
  // cpu request and area decode

  assign req.store = STORE_I;
  assign req.lpm = LPM_I;
  assign req.pc  = PC_I;
  assign req.z   = Z_I;

  assign fuse_start = (fuse_ff == 2'h0) ? BOOT_START_0 :
                      (fuse_ff == 2'h1) ? BOOT_START_1 :
                      (fuse_ff == 2'h2) ? BOOT_START_2 :
                                          BOOT_START_3;

  // a fuse value below the fixed split is pulled up to it
  assign boot_start = (fuse_start < HALT_START) ? HALT_START
                                                : fuse_start;

  area_decode u_pc_area (
    .addr_i       (req.pc),
    .boot_start_i (boot_start),
    .area_o       (pc_area)
  );

  area_decode u_z_area (
    .addr_i       (req.z),
    .boot_start_i (boot_start),
    .area_o       (z_area)
  );

  // fuses are static straps: caught once after reset release
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      fuse_ff       <= 2'h0;
      fuse_taken_ff <= 1'b0;
    end else if (!fuse_taken_ff) begin
      fuse_ff       <= BOOT_SIZE_FUSES_I;
      fuse_taken_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // chip erase pin

  pin_sync3 u_erase_sync (
    .clk_i    (CLK_I),
    .resetn_i (RESETN_I),
    .pin_i    (CHIP_ERASE_I),
    .level_o  (erase_lvl)
  );

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      erase_old_ff <= 1'b0;
    end else begin
      erase_old_ff <= erase_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always OKAY

  assign ap_valid = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign wr_ctrl  = wr_pend_ff & (wr_ofs_ff == OFS_CTRL);
  assign wr_stage = wr_pend_ff & (wr_ofs_ff == OFS_STAGE);

  assign status_word = {27'h0000000,
                        refused_ff,
                        (state_ff == S_ARMED),
                        stall_ff,
                        (state_ff == S_PROG),
                        area_busy_ff};

  assign rd_mux = (HADDR_I[7:0] == OFS_CTRL)  ? {29'h0000000, cmd_ff} :
                  (HADDR_I[7:0] == OFS_STAGE) ? {28'h0000000, stage_ff} :
                  (HADDR_I[7:0] == OFS_LOCK)  ? {28'h0000000, lock_ff} :
                  (HADDR_I[7:0] == OFS_STAT)  ? status_word :
                                                32'h00000000;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff  <= 8'h00;
      rdata_ff   <= 32'h00000000;
    end else begin
      wr_pend_ff <= ap_valid & HWRITE_I;
      wr_ofs_ff  <= HADDR_I[7:0];
      if (ap_valid && !HWRITE_I) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign HRDATA_O    = rdata_ff;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // store-program decision

  assign store_armed    = req.store & (state_ff == S_ARMED);
  assign store_from_app = ~pc_area.boot;
  assign prog_cmd       = (cmd_ff == CMD_ERASE) | (cmd_ff == CMD_WRITE);

  // target may be anywhere, including the boot area itself
  assign tgt_wr_lock = z_area.boot ? ~lock_ff[LK_BOOT_WR]
                                   : ~lock_ff[LK_APP_WR];
  assign prog_ok     = prog_cmd & ~tgt_wr_lock & ~store_from_app;
  assign prog_start  = store_armed & prog_ok;

  assign load_go = store_armed & ~store_from_app & (cmd_ff == CMD_LOAD);
  assign reen_go = store_armed & ~store_from_app & (cmd_ff == CMD_REEN);
  assign lock_go = store_armed & ~store_from_app & (cmd_ff == CMD_LOCK);

  // a refused store changes nothing in the flash
  assign refuse_now = req.store & ((state_ff != S_ARMED) | store_from_app |
                                   (prog_cmd & tgt_wr_lock));

  assign arm_expire = (state_ff == S_ARMED) & ~req.store &
                      (arm_cnt_ff == ARM_LAST);
  assign prog_end   = (state_ff == S_PROG) & (prog_cnt_ff == PROG_LAST);

  assign busy_set = prog_start & ~z_area.halt;
  assign busy_clr = load_go | reen_go;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (wr_ctrl && (cmd_t'(HWDATA_I[2:0]) != CMD_NONE)) begin
          nxt_state = S_ARMED;
        end
      end
      S_ARMED: begin
        if (prog_start) begin
          nxt_state = S_PROG;
        end else if (req.store || arm_expire) begin
          nxt_state = S_IDLE;
        end
      end
      S_PROG: begin
        if (prog_end) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // command: writes while armed or programming are dropped
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cmd_ff <= CMD_NONE;
    end else if (wr_ctrl && state_ff == S_IDLE) begin
      cmd_ff <= cmd_t'(HWDATA_I[2:0]);
    end else if (nxt_state == S_IDLE) begin
      cmd_ff <= CMD_NONE;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      arm_cnt_ff <= '0;
    end else if (state_ff == S_ARMED) begin
      arm_cnt_ff <= arm_cnt_ff + AC'(1);
    end else begin
      arm_cnt_ff <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // programming run: page latched at start, count runs to the end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      prog_cnt_ff <= '0;
      page_ff     <= '0;
      stall_ff    <= 1'b0;
    end else begin
      if (prog_start) begin
        page_ff     <= req.z[AW-1:PAGE_W];
        prog_cnt_ff <= '0;
        stall_ff    <= z_area.halt;
      end else if (state_ff == S_PROG) begin
        prog_cnt_ff <= prog_cnt_ff + CW'(1);
        if (prog_end) begin
          stall_ff <= 1'b0;
        end
      end
    end
  end

  // set and clear never coincide: both need an armed store
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      area_busy_ff <= 1'b0;
    end else if (busy_set) begin
      area_busy_ff <= 1'b1;
    end else if (busy_clr) begin
      area_busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      erase_pls_ff   <= 1'b0;
      write_pls_ff   <= 1'b0;
      load_pls_ff    <= 1'b0;
      refused_pls_ff <= 1'b0;
    end else begin
      erase_pls_ff   <= prog_start & (cmd_ff == CMD_ERASE);
      write_pls_ff   <= prog_start & (cmd_ff == CMD_WRITE);
      load_pls_ff    <= load_go;
      refused_pls_ff <= refuse_now;
    end
  end

  // sticky refusal, cleared by the next control write while idle
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      refused_ff <= 1'b0;
    end else if (refuse_now) begin
      refused_ff <= 1'b1;
    end else if (wr_ctrl && state_ff == S_IDLE) begin
      refused_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock fields: software may only program bits, erase restores all

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stage_ff <= LOCK_UNPROG;
    end else if (wr_stage) begin
      stage_ff <= HWDATA_I[3:0];
    end
  end

  // lock_ff is reset on every RESETN_I; power cycles do not exist in this model
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      lock_ff <= LOCK_UNPROG;
    end else if (erase_lvl && !erase_old_ff) begin
      lock_ff <= LOCK_UNPROG;
    end else if (lock_go) begin
      lock_ff <= lock_ff & stage_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program loads and interrupt masking
  // no general memory lock input exists: only lock_ff, area_busy_ff and stall_ff gate loads

  assign lpm_lock_blk =
    ( pc_area.boot & ~z_area.boot & ~lock_ff[LK_APP_RD]) |
    (~pc_area.boot &  z_area.boot & ~lock_ff[LK_BOOT_RD]);

  // reads of the blocked area would return garbage
  assign lpm_busy_blk = area_busy_ff & ~z_area.halt;

  assign irq_app_mask  = ~pc_area.boot & VEC_IN_BOOT_I &
                         ~lock_ff[LK_APP_RD];
  assign irq_boot_mask =  pc_area.boot & ~VEC_IN_BOOT_I &
                         ~lock_ff[LK_BOOT_RD];

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign LPM_ALLOW_O    = req.lpm & ~lpm_lock_blk & ~lpm_busy_blk & ~stall_ff;
  assign IRQ_MASK_O     = irq_app_mask | irq_boot_mask;
  assign CPU_STALL_O    = stall_ff;
  assign AREA_READ_EN_O = ~area_busy_ff;
  assign STORE_REFUSED_O = refused_pls_ff;
  assign FL_ERASE_O     = erase_pls_ff;
  assign FL_WRITE_O     = write_pls_ff;
  assign FL_LOAD_O      = load_pls_ff;
  assign FL_PAGE_O      = page_ff;

endmodule // flash_guard

// File: verification/flash_guard_checker.sv
// concurrent checks on the flash guard cpu-side and flash macro ports
// sees only top-level ports; attached by the bind below
`timescale 1ns/1ps
module flash_guard_checker
  import flash_guard_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC_DEF
) (
  input wire logic            CLK_I,
  input wire logic            RESETN_I,
  input wire logic            STORE_I,
  input wire logic            LPM_I,
  input wire logic [AW-1:0]   PC_I,
  input wire logic [AW-1:0]   Z_I,
  input wire logic            VEC_IN_BOOT_I,
  input wire logic [1:0]      BOOT_SIZE_FUSES_I,
  input wire logic            STORE_REFUSED_O,
  input wire logic            LPM_ALLOW_O,
  input wire logic            CPU_STALL_O,
  input wire logic            AREA_READ_EN_O,
  input wire logic            IRQ_MASK_O,
  input wire logic            FL_ERASE_O,
  input wire logic            FL_WRITE_O,
  input wire logic [PG_W-1:0] FL_PAGE_O
);
  logic [AW-1:0] bstart;
  logic          pc_boot;
  logic          prog_pulse;
  assign bstart = (BOOT_SIZE_FUSES_I == 2'h0) ? BOOT_START_0 :
                  (BOOT_SIZE_FUSES_I == 2'h1) ? BOOT_START_1 :
                  (BOOT_SIZE_FUSES_I == 2'h2) ? BOOT_START_2 : BOOT_START_3;
  assign pc_boot    = PC_I >= bstart;
  assign prog_pulse = FL_ERASE_O || FL_WRITE_O;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  ////////////////////////////////////////////////////////////////////
  app_refuse_a: assert property (STORE_I && !pc_boot |=> STORE_REFUSED_O && !prog_pulse)
    else $error("store from application was not refused");
  halt_stall_a: assert property (prog_pulse && $past(Z_I) >= HALT_START |-> CPU_STALL_O)
    else $error("halting-area program did not stall");
  conc_run_a: assert property (prog_pulse && $past(Z_I) < HALT_START |->
    !CPU_STALL_O && !AREA_READ_EN_O) else $error("concurrent program stalled or not busy");
  stall_hold_a: assert property ($rose(CPU_STALL_O) |-> CPU_STALL_O [*8])
    else $error("stall dropped early");
  stall_noread_a: assert property (CPU_STALL_O |-> !LPM_ALLOW_O)
    else $error("load allowed during stall");
  busy_noread_a: assert property (LPM_I && !AREA_READ_EN_O && Z_I < HALT_START
    |-> !LPM_ALLOW_O) else $error("blocked area load allowed");
  page_latch_a: assert property (prog_pulse |-> FL_PAGE_O == $past(Z_I[AW-1:PAGE_W]))
    else $error("page not latched from target");
  irq_same_a: assert property (VEC_IN_BOOT_I == pc_boot |-> !IRQ_MASK_O)
    else $error("interrupts masked without cause");
  same_area_a: assert property (LPM_I && !CPU_STALL_O && ((Z_I >= bstart) == pc_boot)
    && (AREA_READ_EN_O || Z_I >= HALT_START) |-> LPM_ALLOW_O) else $error("same-area load refused");
endmodule // flash_guard_checker

bind flash_guard flash_guard_checker #(.PROG_CYCLES(PROG_CYCLES)) checker_u (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .STORE_I(STORE_I), .LPM_I(LPM_I), .PC_I(PC_I), .Z_I(Z_I),
  .VEC_IN_BOOT_I(VEC_IN_BOOT_I), .BOOT_SIZE_FUSES_I(BOOT_SIZE_FUSES_I),
  .STORE_REFUSED_O(STORE_REFUSED_O), .LPM_ALLOW_O(LPM_ALLOW_O), .CPU_STALL_O(CPU_STALL_O),
  .AREA_READ_EN_O(AREA_READ_EN_O), .IRQ_MASK_O(IRQ_MASK_O), .FL_ERASE_O(FL_ERASE_O),
  .FL_WRITE_O(FL_WRITE_O), .FL_PAGE_O(FL_PAGE_O));

// File: verification/cpu_model.sv
// behavioural cpu core issuing store and load program requests
// tasks are called by the bench just after a rising edge
`timescale 1ns/1ps
module cpu_model
  import flash_guard_pkg::*;
(
  // clock and area status
  input  wire logic          clk_i,
  input  wire logic          area_read_en_i,
  // requests
  output logic               store_o,
  output logic               lpm_o,
  output logic [AW-1:0]      pc_o,
  output logic [AW-1:0]      z_o,
  output logic               vec_boot_o
);
  initial begin
    store_o = 1'b0;
    lpm_o = 1'b0;
    pc_o = '0;
    z_o = '0;
    vec_boot_o = 1'b0;
  end
  task automatic store(input logic [AW-1:0] pc, input logic [AW-1:0] z);
    pc_o <= pc;
    z_o <= z;
    store_o <= 1'b1;
    @(posedge clk_i);
    store_o <= 1'b0;
  endtask
  // bold lets a scenario break the no-read rule on purpose
  task automatic load(input logic [AW-1:0] pc, z, input logic vec, bold);
    pc_o <= pc;
    z_o <= z;
    vec_boot_o <= vec;
    lpm_o <= bold || area_read_en_i || (z >= HALT_START);
  endtask
  task automatic idle();
    lpm_o <= 1'b0;
  endtask
endmodule // cpu_model

// File: verification/tb.sv
// self-checking bench for the flash guard
// ahb master and cpu model share the one 100 MHz clock
`timescale 1ns/1ps
module tb;
  import flash_guard_pkg::*;
  localparam int PROG = 20;
  typedef struct {
    cmd_t          cmd;
    logic [AW-1:0] pc, z;
    logic          rfs, stall, busy;
  } row_t;
  logic            clk, rst_n, hsel, hwrite, chip_erase, hready, hresp;
  logic [31:0]     haddr, hwdata, hrdata, junk;
  logic [1:0]      htrans, fuses;
  logic            store, lpm, vec, refused, lpm_ok, stall, area_en, irq_mask;
  logic            fl_erase, fl_write, fl_load;
  logic [AW-1:0]   pc, z;
  logic [PG_W-1:0] fl_page;
  int              n_errors, samples_checked, cycles;
  // boot area starts at 0xE00 with fuses 1
  row_t rows [8] = '{
    '{CMD_ERASE, 12'hF90, 12'h100, 1'b0, 1'b0, 1'b1},
    '{CMD_REEN,  12'hF90, 12'h000, 1'b0, 1'b0, 1'b0},
    '{CMD_ERASE, 12'hF90, 12'h100, 1'b0, 1'b0, 1'b1},
    '{CMD_LOAD,  12'hF90, 12'h020, 1'b0, 1'b0, 1'b0},
    '{CMD_WRITE, 12'hE00, 12'hE20, 1'b0, 1'b1, 1'b0},
    '{CMD_ERASE, 12'hD00, 12'h100, 1'b1, 1'b0, 1'b0},
    '{CMD_WRITE, 12'h000, 12'hC40, 1'b1, 1'b0, 1'b0},
    '{CMD_ERASE, 12'hF90, 12'hC40, 1'b0, 1'b1, 1'b0}};

  flash_guard #(.PROG_CYCLES(PROG)) DUT (
    .CLK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .STORE_I(store), .LPM_I(lpm),
    .PC_I(pc), .Z_I(z), .VEC_IN_BOOT_I(vec), .STORE_REFUSED_O(refused), .LPM_ALLOW_O(lpm_ok),
    .CPU_STALL_O(stall), .AREA_READ_EN_O(area_en), .IRQ_MASK_O(irq_mask),
    .BOOT_SIZE_FUSES_I(fuses), .CHIP_ERASE_I(chip_erase), .FL_ERASE_O(fl_erase),
    .FL_WRITE_O(fl_write), .FL_LOAD_O(fl_load), .FL_PAGE_O(fl_page));
  cpu_model cpu (
    .clk_i(clk), .area_read_en_i(area_en), .store_o(store), .lpm_o(lpm), .pc_o(pc), .z_o(z),
    .vec_boot_o(vec));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t %s got %0h want %0h", $time, m, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    chk(d, e, "register read");
    chk(hresp, 1'b0, "bus response");
  endtask
  // one armed store, then checks at the pulse cycle and once programming is over
  task automatic prog(input row_t r);
    xfer(1'b1, OFS_CTRL, {29'h0, r.cmd}, junk);
    cpu.store(r.pc, r.z);
    // pulses stand only in the cycle right after the store edge
    #1;
    chk(refused, r.rfs, "refusal");
    chk(fl_erase, r.cmd == CMD_ERASE && !r.rfs, "erase pulse");
    chk(fl_write, r.cmd == CMD_WRITE && !r.rfs, "write pulse");
    chk(fl_load, r.cmd == CMD_LOAD && !r.rfs, "load pulse");
    if (!r.rfs && r.cmd inside {CMD_ERASE, CMD_WRITE}) chk(fl_page, r.z[AW-1:PAGE_W], "page");
    chk(stall, r.stall, "stall at start");
    repeat (PROG + 3) @(posedge clk);
    #1;
    chk(stall, 1'b0, "stall after end");
    chk(area_en, !r.busy, "area readable");
    rchk(OFS_STAT, {27'h0, r.rfs, 3'h0, r.busy});
  endtask
  task automatic set_lock(input logic [3:0] v);
    xfer(1'b1, OFS_STAGE, {28'h0, v}, junk);
    prog(row_t'{CMD_LOCK, 12'hF90, 12'h000, 1'b0, 1'b0, 1'b0});
  endtask
  task automatic lchk(input logic [AW-1:0] p, a, input logic v, bold, e_ok, e_mask);
    cpu.load(p, a, v, bold);
    @(posedge clk);
    #1;
    chk(lpm_ok, e_ok, "load permission");
    chk(irq_mask, e_mask, "interrupt mask");
    cpu.idle();
    @(posedge clk);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {hsel, hwrite, chip_erase, rst_n} = 4'h0;
    {haddr, hwdata, htrans} = '0;
    fuses = 2'h1;
    {n_errors, samples_checked, cycles} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rchk(OFS_CTRL, 32'h0);
    rchk(OFS_STAGE, 32'hF);
    rchk(OFS_LOCK, 32'hF);
    rchk(8'h40, 32'h0);
    foreach (rows[i]) prog(rows[i]);
    // store one cycle past the arming window must be refused
    xfer(1'b1, OFS_CTRL, {29'h0, CMD_ERASE}, junk);
    repeat (ARM_CYCLES) @(posedge clk);
    cpu.store(12'hF90, 12'h100);
    #1;
    chk(refused, 1'b1, "late store refused");
    chk(fl_erase, 1'b0, "late store erased");
    lchk(12'hF90, 12'hF00, 1'b0, 1'b0, 1'b1, 1'b0);
    set_lock(4'hE);
    rchk(OFS_LOCK, 32'hE);
    prog(row_t'{CMD_WRITE, 12'hF90, 12'h100, 1'b1, 1'b0, 1'b0});
    set_lock(4'hB);
    rchk(OFS_LOCK, 32'hA);
    prog(row_t'{CMD_ERASE, 12'hF90, 12'hF00, 1'b1, 1'b0, 1'b0});
    set_lock(4'hF);
    xfer(1'b1, OFS_LOCK, 32'h0, junk);
    rchk(OFS_LOCK, 32'hA);
    chip_erase <= 1'b1;
    repeat (5) @(posedge clk);
    chip_erase <= 1'b0;
    repeat (5) @(posedge clk);
    rchk(OFS_LOCK, 32'hF);
    set_lock(4'hD);
    lchk(12'hF90, 12'h100, 1'b1, 1'b0, 1'b0, 1'b0);
    lchk(12'h100, 12'h100, 1'b1, 1'b0, 1'b1, 1'b1);
    set_lock(4'h7);
    lchk(12'h100, 12'hF00, 1'b0, 1'b0, 1'b0, 1'b0);
    lchk(12'hF90, 12'hF00, 1'b0, 1'b0, 1'b1, 1'b1);
    // second reset with the largest boot area
    rst_n <= 1'b0;
    fuses <= 2'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    prog(row_t'{CMD_ERASE, 12'hD00, 12'h100, 1'b0, 1'b0, 1'b1});
    lchk(12'hD00, 12'h100, 1'b1, 1'b1, 1'b0, 1'b0);
    close_out();
  end
endmodule // tb
